// File: src/param_ctrl_pkg.sv
// Shared constants, encodings and decoders for the parameter input and subtask control block.
package param_ctrl_pkg;

   // Register byte offsets.
   localparam logic [7:0] OFS_DECL      = 8'h00;
   localparam logic [7:0] OFS_MEM_SIZE  = 8'h04;
   localparam logic [7:0] OFS_FILE_REG  = 8'h08;
   localparam logic [7:0] OFS_BAT_ACT   = 8'h0c;
   localparam logic [7:0] OFS_BAT_OUT   = 8'h10;
   localparam logic [7:0] OFS_START_SET = 8'h14;
   localparam logic [7:0] OFS_START_SEL = 8'h18;
   localparam logic [7:0] OFS_STOP_SET  = 8'h1c;
   localparam logic [7:0] OFS_STOP_SEL  = 8'h20;
   localparam logic [7:0] OFS_RELAY_CMD = 8'h24;
   localparam logic [7:0] OFS_STATUS    = 8'h28;
   localparam logic [7:0] OFS_GP_IMAGE  = 8'h2c;
   localparam logic [7:0] OFS_CAPACITY  = 8'h30;

   // Dedicated input declaration codes.
   localparam logic [2:0] DECL_NONE  = 3'h0;
   localparam logic [2:0] DECL_MANU  = 3'h1;
   localparam logic [2:0] DECL_PINS  = 3'h2;
   localparam logic [2:0] DECL_MIXED = 3'h3;
   localparam logic [2:0] DECL_GP    = 3'h4;

   // Battery low action codes.
   localparam logic [1:0] BAT_LED    = 2'h0;
   localparam logic [1:0] BAT_RELAY  = 2'h1;
   localparam logic [1:0] BAT_OUTPUT = 2'h2;

   // Subtask start and stop setting codes.
   localparam logic [1:0] START_MODE  = 2'h0;
   localparam logic [1:0] START_INPUT = 2'h1;
   localparam logic [1:0] START_BOTH  = 2'h2;
   localparam logic [1:0] STOP_MODE   = 2'h0;
   localparam logic [1:0] STOP_INPUT  = 2'h1;

   // Memory sizes and file registers, in program steps.
   localparam logic [12:0] STEPS_LARGE   = 13'h1e78;
   localparam logic [12:0] STEPS_SMALL   = 13'h0ed8;
   localparam logic [11:0] FILE_REG_MAX  = 12'hbb8;
   localparam logic [12:0] FILE_REG_BASE = 13'h0fa0;

   // Input and output numbers, held as the octal number read as binary.
   localparam int         GEN_N           = 56;
   localparam int         DED_N           = 6;
   localparam logic [7:0] GEN_LAST        = 8'h37;
   localparam logic [7:0] SINGLE_GEN_LAST = 8'h03;
   localparam logic [7:0] DED_FIRST       = 8'hfa;
   localparam logic [7:0] SINGLE_DED_LO   = 8'hfd;

   // Dedicated pin and relay bit positions: Y axis low, X axis high.
   localparam int Y_BITS = 3;

   typedef enum logic {SUB_IDLE = 1'b0, SUB_RUN = 1'b1} subState_e;

   // True when an input number exists on the variant.
   function automatic logic inputSelOk(input logic [7:0] sel, input logic twoAxis);
      if (twoAxis)
         inputSelOk = (sel <= GEN_LAST) || (sel >= DED_FIRST);
      else
         inputSelOk = (sel <= SINGLE_GEN_LAST) || (sel >= SINGLE_DED_LO);
   endfunction

   // True when an output relay number exists.
   function automatic logic outputSelOk(input logic [7:0] sel);
      outputSelOk = sel <= GEN_LAST;
   endfunction

endpackage

// File: src/pin_sync.sv
// Two-flop synchroniser for a group of pin levels.
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   // Clock, reset and enable.
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   input  wire logic             clkEn,
   // Levels.
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   // The first stage feeds only the second stage.
   always_comb begin
      meta_d = clkEn ? asyncIn : meta_q;
      sync_d = clkEn ? meta_q : sync_q;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign syncOut = sync_q;
endmodule // pin_sync

// File: src/input_pick.sv
// Picks the level of one numbered input from the general and dedicated input sets.
`timescale 1ns/1ps
module input_pick #(
   parameter bit TWO_AXIS = 1'b1
) (
   // Input sets.
   input  wire logic [param_ctrl_pkg::GEN_N-1:0] genIn,
   input  wire logic [param_ctrl_pkg::DED_N-1:0] dedIn,
   // Selected number.
   input  wire logic [7:0]                       sel,
   output logic                                  level
);
   logic [7:0] dedIdx;

   // A number the variant lacks falls back to input 0.
   always_comb begin
      dedIdx = sel - param_ctrl_pkg::DED_FIRST;
      level  = genIn[0];
      if (param_ctrl_pkg::inputSelOk(sel, TWO_AXIS)) begin
         if (sel >= param_ctrl_pkg::DED_FIRST)
            level = dedIn[dedIdx[2:0]];
         else
            level = genIn[sel[5:0]];
      end
   end
endmodule // input_pick

// File: src/param_input_subtask_control.sv
// Jog input routing, system settings and subtask start/stop control behind an AHB-Lite slave.
//
// Decided for this implementation: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps

// What this block does
// - Dedicated jog and zero-return inputs may serve as general inputs by declaration.
// - Declaration 0: never general inputs; dedicated pins and command relays both honoured.
// - Declaration 1: general inputs in automatic; pins and relays honoured only in manual.
// - Declaration 2: never general inputs; pins always honoured; relays never honoured.
// - Declaration 4: always general inputs; pins never honoured; relays always honoured.
// - Command relays give zero return, forward and reverse jog per axis.
// - As general inputs, X axis shows at 375-377 and Y axis at 372-374.
// - Program memory is 7.8K or 3.8K steps; single-axis only 3.8K.
// - Zero to 3000 file registers from D4000 each take one step; reset count zero.
// - Battery low, two-axis only: 0 lights LED, 1 sets status relay, 2 lights LED and output.
// - Battery low output is relay 0 to 67, reset 0, used only with action 2.
// - Start setting 0, the default, starts the subtask on manual to automatic.
// - Start setting 1 starts the subtask only when the start input turns on.
// - Start setting 2 starts on manual to automatic or the start input turning on.
// - Start input is X0-X3 or X375-X377 single-axis, X0-X67 or X372-X377 two-axis.
// - Stop setting 0, the default, stops the subtask on automatic to manual.
// - Stop setting 1 stops on the stop input turning on or automatic to manual.
// - The stop input number is used only with stop setting 1.
module param_input_subtask_control #(
   parameter bit TWO_AXIS = 1'b1
) (
   // Clock, reset and enable.
   input  wire logic                             sys_clk,
   input  wire logic                             rst_n,
   input  wire logic                             clkEn,
   // AHB-Lite slave.
   input  wire logic                             hsel,
   input  wire logic [31:0]                      haddr,
   input  wire logic [1:0]                       htrans,
   input  wire logic                             hwrite,
   input  wire logic [2:0]                       hsize,
   input  wire logic [31:0]                      hwdata,
   input  wire logic                             hready,
   output logic                                  hreadyout,
   output logic      [31:0]                      hrdata,
   output logic                                  hresp,
   // Field pins.
   input  wire logic                             autoModePin,
   input  wire logic [param_ctrl_pkg::DED_N-1:0] dedPins,
   input  wire logic [param_ctrl_pkg::GEN_N-1:0] genPins,
   input  wire logic                             batteryLowPin,
   // Results.
   output logic      [param_ctrl_pkg::DED_N-1:0] jogCmd,
   output logic      [param_ctrl_pkg::DED_N-1:0] gpInputs,
   output logic      [param_ctrl_pkg::GEN_N-1:0] outRelay,
   output logic                                  batteryLed,
   output logic                                  batteryRelay,
   output logic                                  subtaskRun,
   output logic                                  subtaskStart,
   output logic                                  subtaskStop,
   output logic      [12:0]                      programSteps,
   output logic      [12:0]                      freeSteps
);
   localparam int SYNC_W = param_ctrl_pkg::GEN_N + param_ctrl_pkg::DED_N + 2;
   localparam logic [param_ctrl_pkg::DED_N-1:0] AXIS_MASK = TWO_AXIS ? 6'h3f : 6'h38;

   // Synchronised pins.
   logic [SYNC_W-1:0]                pinSync;
   logic                             autoS;
   logic                             batS;
   logic [param_ctrl_pkg::DED_N-1:0] dedS;
   logic [param_ctrl_pkg::GEN_N-1:0] genS;

   pin_sync #(.WIDTH(SYNC_W)) u_sync (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .clkEn   (clkEn),
      .asyncIn ({autoModePin, batteryLowPin, dedPins, genPins}),
      .syncOut (pinSync)
   );
   assign {autoS, batS, dedS, genS} = pinSync;

   // Bus and settings state.
   logic        busWr_q, busWr_d;
   logic [7:0]  busAddr_q, busAddr_d;
   logic        busHit_q, busHit_d;
   logic [31:0] rdata_q, rdata_d;
   logic        ready_q;
   logic [2:0]  decl_q, decl_d;
   logic        memSel_q, memSel_d;
   logic [11:0] fileReg_q, fileReg_d;
   logic [1:0]  batAct_q, batAct_d;
   logic [7:0]  batOut_q, batOut_d;
   logic [1:0]  startSet_q, startSet_d;
   logic [7:0]  startSel_q, startSel_d;
   logic [1:0]  stopSet_q, stopSet_d;
   logic [7:0]  stopSel_q, stopSel_d;
   logic [5:0]  relay_q, relay_d;

   // Effective settings.
   logic [2:0]  declEff;
   logic [1:0]  batEff;
   logic [1:0]  startEff;
   logic [1:0]  stopEff;
   logic [11:0] fileEff;
   logic [12:0] memSteps;
   logic [12:0] fileEnd;

   // Outputs and subtask state.
   logic [5:0]             jog_q, jog_d, gp_q, gp_d;
   logic [55:0]            out_q, out_d;
   logic                   led_q, led_d, batRel_q, batRel_d;
   param_ctrl_pkg::subState_e sub_q, sub_d;
   logic                   startP_q, startP_d, stopP_q, stopP_d;
   logic [12:0]            prog_q, free_q;
   logic                   autoPrev_q, startPrev_q, stopPrev_q;
   logic                   startLvl, stopLvl;
   logic                   manuToAuto, autoToManu, startRise, stopRise, startEv, stopEv;
   logic                   gpOn, dedOn, relOn;

   input_pick #(.TWO_AXIS(TWO_AXIS)) u_startPick (
      .genIn (genS),
      .dedIn (dedS),
      .sel   (startSel_q),
      .level (startLvl)
   );
   input_pick #(.TWO_AXIS(TWO_AXIS)) u_stopPick (
      .genIn (genS),
      .dedIn (dedS),
      .sel   (stopSel_q),
      .level (stopLvl)
   );

   // Setting decode; codes the variant lacks take the reset value.
   always_comb begin
      declEff  = (decl_q <= param_ctrl_pkg::DECL_GP) ? decl_q : param_ctrl_pkg::DECL_NONE;
      batEff   = (batAct_q <= param_ctrl_pkg::BAT_OUTPUT) ? batAct_q
                                                           : param_ctrl_pkg::BAT_LED;
      startEff = (startSet_q <= param_ctrl_pkg::START_BOTH) ? startSet_q
                                                           : param_ctrl_pkg::START_MODE;
      stopEff  = (stopSet_q <= param_ctrl_pkg::STOP_INPUT) ? stopSet_q
                                                          : param_ctrl_pkg::STOP_MODE;
      fileEff  = (fileReg_q <= param_ctrl_pkg::FILE_REG_MAX) ? fileReg_q : 12'h000;
      memSteps = (TWO_AXIS && !memSel_q) ? param_ctrl_pkg::STEPS_LARGE
                                         : param_ctrl_pkg::STEPS_SMALL;
      fileEnd  = (fileEff == 12'h000) ? 13'h0000
                 : 13'(param_ctrl_pkg::FILE_REG_BASE + {1'b0, fileEff} - 13'h0001);
   end

   // Declaration table: general input use, dedicated pins, command relays.
   always_comb begin
      gpOn  = 1'b0;
      dedOn = 1'b1;
      relOn = 1'b1;
      unique case (declEff)
         param_ctrl_pkg::DECL_MANU: begin
            gpOn  = autoS;
            dedOn = !autoS;
            relOn = !autoS;
         end
         param_ctrl_pkg::DECL_PINS: relOn = 1'b0;
         param_ctrl_pkg::DECL_MIXED: begin
            gpOn  = autoS;
            relOn = !autoS;
         end
         param_ctrl_pkg::DECL_GP: begin
            gpOn  = 1'b1;
            dedOn = 1'b0;
         end
         default: ;
      endcase
   end

   // Jog commands and the general input image.
   always_comb begin
      jog_d = ((dedOn ? dedS : 6'h00) | (relOn ? relay_q : 6'h00)) & AXIS_MASK;
      gp_d  = gpOn ? (dedS & AXIS_MASK) : 6'h00;
   end

   // Battery low indication.
   always_comb begin
      led_d    = 1'b0;
      batRel_d = 1'b0;
      out_d    = '0;
      if (batS && TWO_AXIS) begin
         unique case (batEff)
            param_ctrl_pkg::BAT_LED:   led_d = 1'b1;
            param_ctrl_pkg::BAT_RELAY: batRel_d = 1'b1;
            param_ctrl_pkg::BAT_OUTPUT: begin
               led_d = 1'b1;
               out_d[param_ctrl_pkg::outputSelOk(batOut_q) ? batOut_q[5:0] : 6'h00] = 1'b1;
            end
            default: ;
         endcase
      end
   end

   // Subtask start and stop events.
   always_comb begin
      manuToAuto = autoS && !autoPrev_q;
      autoToManu = !autoS && autoPrev_q;
      startRise  = startLvl && !startPrev_q;
      stopRise   = stopLvl && !stopPrev_q;
      unique case (startEff)
         param_ctrl_pkg::START_INPUT: startEv = startRise;
         param_ctrl_pkg::START_BOTH:  startEv = manuToAuto || startRise;
         default:                     startEv = manuToAuto;
      endcase
      // The stop input is ignored unless stop setting 1 asks for it.
      stopEv = autoToManu || ((stopEff == param_ctrl_pkg::STOP_INPUT) && stopRise);
   end

   // A stop in the same cycle as a start wins, so a bouncing input cannot rearm it.
   always_comb begin
      sub_d    = sub_q;
      startP_d = 1'b0;
      stopP_d  = 1'b0;
      unique case (sub_q)
         param_ctrl_pkg::SUB_IDLE: begin
            if (startEv && !stopEv) begin
               sub_d    = param_ctrl_pkg::SUB_RUN;
               startP_d = 1'b1;
            end
         end
         param_ctrl_pkg::SUB_RUN: begin
            if (stopEv) begin
               sub_d   = param_ctrl_pkg::SUB_IDLE;
               stopP_d = 1'b1;
            end
         end
      endcase
   end

   // Bus address phase and register writes.
   always_comb begin
      busWr_d    = 1'b0;
      busAddr_d  = busAddr_q;
      busHit_d   = 1'b0;
      decl_d     = decl_q;
      memSel_d   = memSel_q;
      fileReg_d  = fileReg_q;
      batAct_d   = batAct_q;
      batOut_d   = batOut_q;
      startSet_d = startSet_q;
      startSel_d = startSel_q;
      stopSet_d  = stopSet_q;
      stopSel_d  = stopSel_q;
      relay_d    = relay_q;
      if (busWr_q && busHit_q) begin
         unique case (busAddr_q)
            param_ctrl_pkg::OFS_DECL:      decl_d = hwdata[2:0];
            param_ctrl_pkg::OFS_MEM_SIZE:  memSel_d = hwdata[0];
            param_ctrl_pkg::OFS_FILE_REG:  fileReg_d = hwdata[11:0];
            param_ctrl_pkg::OFS_BAT_ACT:   batAct_d = hwdata[1:0];
            param_ctrl_pkg::OFS_BAT_OUT:   batOut_d = hwdata[7:0];
            param_ctrl_pkg::OFS_START_SET: startSet_d = hwdata[1:0];
            param_ctrl_pkg::OFS_START_SEL: startSel_d = hwdata[7:0];
            param_ctrl_pkg::OFS_STOP_SET:  stopSet_d = hwdata[1:0];
            param_ctrl_pkg::OFS_STOP_SEL:  stopSel_d = hwdata[7:0];
            param_ctrl_pkg::OFS_RELAY_CMD: relay_d = hwdata[5:0] & AXIS_MASK;
            default: ;
         endcase
      end
      rdata_d = 32'h0000_0000;
      if (hsel && htrans[1] && hready) begin
         busWr_d   = hwrite;
         busAddr_d = haddr[7:0];
         busHit_d  = (haddr[31:8] == 24'h000000);
         if (!hwrite && busHit_d) begin
            unique case (haddr[7:0])
               param_ctrl_pkg::OFS_DECL:      rdata_d[2:0] = decl_q;
               param_ctrl_pkg::OFS_MEM_SIZE:  rdata_d[0] = memSel_q;
               param_ctrl_pkg::OFS_FILE_REG:  rdata_d[11:0] = fileReg_q;
               param_ctrl_pkg::OFS_BAT_ACT:   rdata_d[1:0] = batAct_q;
               param_ctrl_pkg::OFS_BAT_OUT:   rdata_d[7:0] = batOut_q;
               param_ctrl_pkg::OFS_START_SET: rdata_d[1:0] = startSet_q;
               param_ctrl_pkg::OFS_START_SEL: rdata_d[7:0] = startSel_q;
               param_ctrl_pkg::OFS_STOP_SET:  rdata_d[1:0] = stopSet_q;
               param_ctrl_pkg::OFS_STOP_SEL:  rdata_d[7:0] = stopSel_q;
               param_ctrl_pkg::OFS_RELAY_CMD: rdata_d[5:0] = relay_q;
               param_ctrl_pkg::OFS_STATUS:
                  rdata_d[10:0] = {jog_q, batRel_q, led_q, batS, autoS,
                                   sub_q == param_ctrl_pkg::SUB_RUN};
               param_ctrl_pkg::OFS_GP_IMAGE:  rdata_d[5:0] = gp_q;
               param_ctrl_pkg::OFS_CAPACITY:  rdata_d = {3'h0, fileEnd, 3'h0, free_q};
               default: ;
            endcase
         end
      end
   end

   // The whole block holds still while clkEn is low, bus included.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         busWr_q     <= 1'b0;
         busAddr_q   <= 8'h00;
         busHit_q    <= 1'b0;
         rdata_q     <= 32'h0000_0000;
         ready_q     <= 1'b0;
         decl_q      <= param_ctrl_pkg::DECL_NONE;
         memSel_q    <= 1'b0;
         fileReg_q   <= 12'h000;
         batAct_q    <= param_ctrl_pkg::BAT_LED;
         batOut_q    <= 8'h00;
         startSet_q  <= param_ctrl_pkg::START_MODE;
         startSel_q  <= 8'h00;
         stopSet_q   <= param_ctrl_pkg::STOP_MODE;
         stopSel_q   <= 8'h00;
         relay_q     <= 6'h00;
         jog_q       <= 6'h00;
         gp_q        <= 6'h00;
         out_q       <= '0;
         led_q       <= 1'b0;
         batRel_q    <= 1'b0;
         sub_q       <= param_ctrl_pkg::SUB_IDLE;
         startP_q    <= 1'b0;
         stopP_q     <= 1'b0;
         prog_q      <= param_ctrl_pkg::STEPS_SMALL;
         free_q      <= param_ctrl_pkg::STEPS_SMALL;
         autoPrev_q  <= 1'b0;
         startPrev_q <= 1'b0;
         stopPrev_q  <= 1'b0;
      end else if (clkEn) begin
         busWr_q     <= busWr_d;
         busAddr_q   <= busAddr_d;
         busHit_q    <= busHit_d;
         rdata_q     <= rdata_d;
         ready_q     <= 1'b1;
         decl_q      <= decl_d;
         memSel_q    <= memSel_d;
         fileReg_q   <= fileReg_d;
         batAct_q    <= batAct_d;
         batOut_q    <= batOut_d;
         startSet_q  <= startSet_d;
         startSel_q  <= startSel_d;
         stopSet_q   <= stopSet_d;
         stopSel_q   <= stopSel_d;
         relay_q     <= relay_d;
         jog_q       <= jog_d;
         gp_q        <= gp_d;
         out_q       <= out_d;
         led_q       <= led_d;
         batRel_q    <= batRel_d;
         sub_q       <= sub_d;
         startP_q    <= startP_d;
         stopP_q     <= stopP_d;
         prog_q      <= memSteps;
         free_q      <= 13'(memSteps - {1'b0, fileEff});
         autoPrev_q  <= autoS;
         startPrev_q <= startLvl;
         stopPrev_q  <= stopLvl;
      end
   end

   assign hreadyout    = ready_q;
   assign hrdata       = rdata_q;
   assign hresp        = 1'b0;
   assign jogCmd       = jog_q;
   assign gpInputs     = gp_q;
   assign outRelay     = out_q;
   assign batteryLed   = led_q;
   assign batteryRelay = batRel_q;
   assign subtaskRun   = (sub_q == param_ctrl_pkg::SUB_RUN);
   assign subtaskStart = startP_q;
   assign subtaskStop  = stopP_q;
   assign programSteps = prog_q;
   assign freeSteps    = free_q;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n || !clkEn);

   sequence manuToAutoSeq;
      !autoS ##1 autoS;
   endsequence
   sequence autoToManuSeq;
      autoS ##1 !autoS;
   endsequence

   decl_zero_gp_a: assert property (declEff == param_ctrl_pkg::DECL_NONE |=> gp_q == 6'h00)
      else $error("General inputs active under declaration 0.");
   decl_one_auto_a: assert property (
      (declEff == param_ctrl_pkg::DECL_MANU && autoS) |=> jog_q == 6'h00)
      else $error("Jog command honoured in automatic under declaration 1.");
   decl_two_relay_a: assert property (
      declEff == param_ctrl_pkg::DECL_PINS |=> jog_q == ($past(dedS) & AXIS_MASK))
      else $error("Command relay honoured under declaration 2.");
   decl_four_route_a: assert property (
      declEff == param_ctrl_pkg::DECL_GP
      |=> gp_q == ($past(dedS) & AXIS_MASK) && jog_q == $past(relay_q))
      else $error("Declaration 4 routing wrong.");
   battery_relay_a: assert property (
      (batS && batEff == param_ctrl_pkg::BAT_RELAY && TWO_AXIS) |=> batRel_q && !led_q)
      else $error("Battery status relay not set.");
   battery_output_a: assert property ((batEff != param_ctrl_pkg::BAT_OUTPUT)
      |=> out_q == '0)
      else $error("Battery output driven outside action 2.");
   subtask_start_a: assert property (manuToAutoSeq ##0 (sub_q == param_ctrl_pkg::SUB_IDLE
      && startEff == param_ctrl_pkg::START_MODE && !stopEv) |=> subtaskRun && startP_q)
      else $error("Subtask did not start on manual to automatic.");
   subtask_stop_a: assert property (autoToManuSeq |-> ##1 !subtaskRun)
      else $error("Subtask still running after automatic to manual.");
   stop_input_ignored_a: assert property (
      (stopEff == param_ctrl_pkg::STOP_MODE && !autoToManu && sub_q == param_ctrl_pkg::SUB_RUN)
      |=> subtaskRun)
      else $error("Stop input acted under stop setting 0.");
   file_count_a: assert property ((fileReg_q > param_ctrl_pkg::FILE_REG_MAX)
      |=> free_q == prog_q)
      else $error("Out of range file register count consumed steps.");
endmodule // param_input_subtask_control

// File: verification/field_model.sv
// Field side model: mode selector, input switches and battery sensor.
`timescale 1ns/1ps
module field_model (
   // Switch levels.
   output logic        autoModePin,
   output logic [5:0]  dedPins,
   output logic [55:0] genPins,
   output logic        batteryLowPin
);
   initial begin
      autoModePin = 1'b0;
      dedPins = 6'h00;
      genPins = 56'h0;
      batteryLowPin = 1'b0;
   end
   // Switches move only just after a clock edge, like real contacts sampled by the device.
   task automatic put(input logic a, input logic [5:0] d, input logic [55:0] g, input logic b);
      autoModePin <= a;
      dedPins <= d;
      genPins <= g;
      batteryLowPin <= b;
   endtask
endmodule // field_model

// File: verification/test_param_input_subtask_control.sv
// Self-checking bench for jog routing, system settings and subtask control.
`timescale 1ns/1ps
module test_param_input_subtask_control;
   logic        sys_clk, rst_n, hsel, hwrite, hreadyout, hresp, autoModePin, batteryLowPin;
   logic        batteryLed, batteryRelay, subtaskRun, subtaskStart, subtaskStop;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata, rv;
   logic [5:0]  dedPins, jogCmd, gpInputs, e;
   logic [55:0] genPins, outRelay;
   logic [12:0] programSteps, freeSteps;
   int          error_cnt = 0, samples_checked = 0, cycles = 0, starts = 0, stops = 0;
   // Per code: {gp auto, gp manual, pins auto, pins manual, relays auto, relays manual}.
   logic [5:0]  tbl [6] = '{6'b001111, 6'b100101, 6'b001100, 6'b101101, 6'b001111, 6'b110011};
   logic [2:0]  codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h4};
   param_input_subtask_control dut (.sys_clk, .rst_n, .clkEn(1'b1), .hsel, .haddr, .htrans,
      .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
      .autoModePin, .dedPins, .genPins, .batteryLowPin, .jogCmd, .gpInputs, .outRelay,
      .batteryLed, .batteryRelay, .subtaskRun, .subtaskStart, .subtaskStop, .programSteps,
      .freeSteps);
   field_model fld (.autoModePin, .dedPins, .genPins, .batteryLowPin);
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   task automatic results();
      $display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      starts <= starts + int'(subtaskStart);
      stops <= stops + int'(subtaskStop);
      if (cycles == 20000) begin
         error_cnt++;
         results();
      end
   end
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
      samples_checked++;
      if (s !== x) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", n, x, s);
      end
   endtask
   // One AHB-Lite single transfer; the wait has no bound of its own, the timeout ends a hang.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      rv = hrdata;
      chk("response", 32'h0, 32'(hresp));
      @(posedge sys_clk);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   initial begin
      rst_n = 1'b0;
      hsel = 1'b0;
      htrans = 2'h0;
      hwrite = 1'b0;
      haddr = 32'h0;
      hwdata = 32'h0;
      wt(16);
      rst_n <= 1'b1;
      wt(2);
      xfer(1'b0, param_ctrl_pkg::OFS_FILE_REG, 32'h0);
      chk("file register count", 32'h0, rv);
      xfer(1'b0, 8'h80, 32'h0);
      chk("unmapped read", 32'h0, rv);
      chk("program steps", 32'(param_ctrl_pkg::STEPS_LARGE), 32'(programSteps));
      fld.put(1'b1, 6'h00, 56'h0, 1'b0);
      wt(6);
      chk("run on auto", 32'h1, 32'(subtaskRun));
      fld.put(1'b0, 6'h00, 56'h0, 1'b0);
      wt(6);
      chk("stop on manual", 32'h0, 32'(subtaskRun));
      xfer(1'b1, param_ctrl_pkg::OFS_START_SET, 32'h1);
      xfer(1'b1, param_ctrl_pkg::OFS_START_SEL, 32'h5);
      fld.put(1'b1, 6'h00, 56'h0, 1'b0);
      wt(6);
      chk("no mode start", 32'h0, 32'(subtaskRun));
      fld.put(1'b1, 6'h00, 56'h20, 1'b0);
      wt(6);
      chk("input start", 32'h1, 32'(subtaskRun));
      xfer(1'b1, param_ctrl_pkg::OFS_STOP_SET, 32'h1);
      xfer(1'b1, param_ctrl_pkg::OFS_STOP_SEL, 32'h6);
      fld.put(1'b1, 6'h00, 56'h60, 1'b0);
      wt(6);
      chk("input stop", 32'h0, 32'(subtaskRun));
      $display("subtask test done");
      xfer(1'b1, param_ctrl_pkg::OFS_RELAY_CMD, 32'h7);
      for (int i = 0; i < 6; i++) begin
         xfer(1'b1, param_ctrl_pkg::OFS_DECL, 32'(codes[i]));
         for (int m = 0; m < 2; m++) begin
            fld.put(m[0], 6'h38, 56'h0, 1'b0);
            wt(6);
            e = tbl[i];
            rv = 32'((e[2+m] ? 6'h38 : 6'h0) | (e[m] ? 6'h07 : 6'h0));
            chk("jog", rv, 32'(jogCmd));
            chk("gp", 32'(e[4+m] ? 6'h38 : 6'h0), 32'(gpInputs));
         end
      end
      xfer(1'b0, param_ctrl_pkg::OFS_GP_IMAGE, 32'h0);
      chk("gp image", 32'h38, rv);
      $display("declaration test done");
      xfer(1'b1, param_ctrl_pkg::OFS_BAT_ACT, 32'h2);
      xfer(1'b1, param_ctrl_pkg::OFS_BAT_OUT, 32'h10);
      fld.put(1'b0, 6'h00, 56'h0, 1'b1);
      wt(6);
      chk("battery output", 32'h3, {30'h0, batteryLed, outRelay[16]});
      xfer(1'b1, param_ctrl_pkg::OFS_BAT_ACT, 32'h1);
      wt(3);
      chk("battery relay", 32'h1, {30'h0, batteryLed, batteryRelay});
      xfer(1'b0, param_ctrl_pkg::OFS_STATUS, 32'h0);
      chk("status", 32'h0f4, rv);
      xfer(1'b1, param_ctrl_pkg::OFS_MEM_SIZE, 32'h1);
      xfer(1'b1, param_ctrl_pkg::OFS_FILE_REG, 32'd3000);
      wt(3);
      chk("small memory", 32'(param_ctrl_pkg::STEPS_SMALL), 32'(programSteps));
      chk("free steps", 32'(param_ctrl_pkg::STEPS_SMALL - 13'd3000), 32'(freeSteps));
      xfer(1'b0, param_ctrl_pkg::OFS_CAPACITY, 32'h0);
      chk("capacity", {3'h0, 13'd6999, 3'h0, 13'd800}, rv);
      xfer(1'b1, param_ctrl_pkg::OFS_FILE_REG, 32'd3001);
      wt(3);
      chk("bad count", 32'(param_ctrl_pkg::STEPS_SMALL), 32'(freeSteps));
      xfer(1'b1, param_ctrl_pkg::OFS_BAT_ACT, 32'h0);
      xfer(1'b1, param_ctrl_pkg::OFS_START_SET, 32'h2);
      fld.put(1'b1, 6'h00, 56'h0, 1'b1);
      wt(6);
      chk("mode start", 32'h1, 32'(subtaskRun));
      chk("battery led", 32'h2, {30'h0, batteryLed, batteryRelay});
      chk("start pulses", 32'h3, 32'(starts));
      chk("stop pulses", 32'h2, 32'(stops));
      $display("settings test done");
      results();
   end
endmodule // test_param_input_subtask_control
